// >>> rtl/upmux_pkg.sv
package upmux_pkg;
    // Selector encodings, two bits per channel
    typedef enum logic [1:0] {
        UPMUX_MODE_UART = 2'h0,
        UPMUX_MODE_CSI_UART = 2'h1,
        UPMUX_MODE_GP_UART = 2'h2,
        UPMUX_MODE_GP = 2'h3
    } upmux_mode_t;
    localparam int UPMUX_SEL_W = 2;
    localparam logic [1:0] UPMUX_SEL_RESET = 2'h3;
    localparam int UPMUX_PINS = 7;
    // Pin positions within a channel's group
    localparam int UPMUX_PIN_RX = 0;
    localparam int UPMUX_PIN_TX = 1;
    localparam int UPMUX_PIN_RTS = 2;
    localparam int UPMUX_PIN_CTS = 3;
    localparam int UPMUX_PIN_DTR = 4;
    localparam int UPMUX_PIN_DCD = 5;
    localparam int UPMUX_PIN_DSR = 6;
    localparam logic [6:0] UPMUX_ZERO7 = 7'h00;
endpackage

// >>> rtl/upmux_if.sv
`timescale 1ns/1ps
`default_nettype none
interface upmux_if;
    // Channel pin groups: device side signals
    logic [6:0] chan1_dev_out;
    logic [6:0] chan1_dev_oe;
    logic [6:0] chan2_dev_out;
    logic [6:0] chan2_dev_oe;
    // Partner side signals
    logic [6:0] chan1_ext_out;
    logic [6:0] chan1_ext_oe;
    logic [6:0] chan2_ext_out;
    logic [6:0] chan2_ext_oe;
    logic shared_serial_clock_in;
    // Resolved pin levels, pull-down when nobody drives
    logic [6:0] chan1_pin;
    logic [6:0] chan2_pin;
    assign chan1_pin = (chan1_dev_oe & chan1_dev_out) | (chan1_ext_oe & chan1_ext_out);
    assign chan2_pin = (chan2_dev_oe & chan2_dev_out) | (chan2_ext_oe & chan2_ext_out);
    modport device (
        output chan1_dev_out, chan1_dev_oe, chan2_dev_out, chan2_dev_oe,
        input chan1_pin, chan2_pin, shared_serial_clock_in
    );
    modport partner (
        output chan1_ext_out, chan1_ext_oe, chan2_ext_out, chan2_ext_oe, shared_serial_clock_in,
        input chan1_pin, chan2_pin
    );
endinterface
`default_nettype wire

// >>> rtl/upmux_device.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Channel one GP mode: all pins port bits
// - Channel one serial modes: data, flow pins serial
// - CSI mode: DTR pin out, DCD pin in
// - CSI mode: DSR pin drives serial clock
// - GP/UART mode: modem pins become port bits
// - Assert RTS when able to receive
// - Partner asserts CTS when able to receive
// - UART mode: assert DTR when ready
// - Partner holds DCD during valid reception
// - Partner holds DSR while ready
// - Channel two data pins serial unless GP
// - Channel two modem pins only in UART and the CSI/UART code
// - One shared serial clock for both channels
module upmux_device
    import upmux_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    upmux_if.device pins,
    input wire logic [1:0] chan1_pin_select,
    input wire logic [1:0] chan2_pin_select,
    input wire logic chan1_tx_serial,
    input wire logic chan1_rx_ready,
    input wire logic chan1_link_ready,
    input wire logic chan2_tx_serial,
    input wire logic chan2_rx_ready,
    input wire logic chan2_link_ready,
    input wire logic clocked_serial_out,
    input wire logic clocked_serial_clock,
    input wire logic [13:0] gp_out,
    input wire logic [13:0] gp_oe,
    output logic chan1_rx_serial,
    output logic chan1_clear_to_send,
    output logic chan1_carrier_detect,
    output logic chan1_set_ready,
    output logic chan2_rx_serial,
    output logic chan2_clear_to_send,
    output logic chan2_carrier_detect,
    output logic chan2_set_ready,
    output logic clocked_serial_in,
    output logic shared_serial_clock,
    output logic [13:0] general_port_bits
);
    ////////////////////////////////////////////////////////////////////////
    // Mode decode helpers
    function automatic logic [6:0] pin_kind1(input logic [1:0] sel);
        // Bit set means serial function owns the pin
        unique case (sel)
            UPMUX_MODE_UART: pin_kind1 = 7'h7f;
            UPMUX_MODE_CSI_UART: pin_kind1 = 7'h7f;
            UPMUX_MODE_GP_UART: pin_kind1 = 7'h0f;
            UPMUX_MODE_GP: pin_kind1 = UPMUX_ZERO7;
        endcase
    endfunction

    function automatic logic [1:0] fold2(input logic [1:0] sel);
        // Channel two has no clocked serial, so that code falls back to UART
        fold2 = (sel == UPMUX_MODE_CSI_UART) ? UPMUX_MODE_UART : sel;
    endfunction

    function automatic logic [6:0] pin_kind2(input logic [1:0] sel);
        unique case (fold2(sel))
            UPMUX_MODE_UART: pin_kind2 = 7'h7f;
            UPMUX_MODE_GP_UART: pin_kind2 = 7'h0f;
            default: pin_kind2 = UPMUX_ZERO7;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers; first stage read only by the second
    logic [14:0] sync1_q;
    logic [14:0] sync2_q;
    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_q <= 15'h0000;
            sync2_q <= 15'h0000;
        end else begin
            sync1_q <= {pins.shared_serial_clock_in, pins.chan2_pin, pins.chan1_pin};
            sync2_q <= sync1_q;
        end
    end

    logic [6:0] p1;
    logic [6:0] p2;
    logic [6:0] ser1;
    logic [6:0] ser2;
    logic csi1;
    logic uart1;
    logic uart2;
    assign p1 = sync2_q[6:0];
    assign p2 = sync2_q[13:7];
    assign ser1 = pin_kind1(chan1_pin_select);
    assign ser2 = pin_kind2(chan2_pin_select);
    assign csi1 = (chan1_pin_select == UPMUX_MODE_CSI_UART);
    assign uart1 = (chan1_pin_select == UPMUX_MODE_UART);
    assign uart2 = (fold2(chan2_pin_select) == UPMUX_MODE_UART);

    ////////////////////////////////////////////////////////////////////////
    // Channel one pin drivers
    logic [6:0] c1_out_q;
    logic [6:0] c1_oe_q;
    always_ff @(posedge clock) begin
        if (reset) begin
            c1_out_q <= UPMUX_ZERO7;
            c1_oe_q <= UPMUX_ZERO7;
        end else begin
            // Port bits where the serial function does not own the pin
            c1_out_q <= gp_out[6:0] & ~ser1;
            c1_oe_q <= gp_oe[6:0] & ~ser1;
            if (ser1[UPMUX_PIN_TX]) begin
                c1_out_q[UPMUX_PIN_TX] <= chan1_tx_serial;
                c1_oe_q[UPMUX_PIN_TX] <= 1'b1;
                c1_out_q[UPMUX_PIN_RTS] <= chan1_rx_ready;
                c1_oe_q[UPMUX_PIN_RTS] <= 1'b1;
            end
            if (uart1) begin
                c1_out_q[UPMUX_PIN_DTR] <= chan1_link_ready;
                c1_oe_q[UPMUX_PIN_DTR] <= 1'b1;
            end
            if (csi1) begin
                c1_out_q[UPMUX_PIN_DTR] <= clocked_serial_out;
                c1_oe_q[UPMUX_PIN_DTR] <= 1'b1;
                c1_out_q[UPMUX_PIN_DSR] <= clocked_serial_clock;
                c1_oe_q[UPMUX_PIN_DSR] <= 1'b1;
            end
        end
    end
    assign pins.chan1_dev_out = c1_out_q;
    assign pins.chan1_dev_oe = c1_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Channel two pin drivers
    logic [6:0] c2_out_q;
    logic [6:0] c2_oe_q;
    always_ff @(posedge clock) begin
        if (reset) begin
            c2_out_q <= UPMUX_ZERO7;
            c2_oe_q <= UPMUX_ZERO7;
        end else begin
            c2_out_q <= gp_out[13:7] & ~ser2;
            c2_oe_q <= gp_oe[13:7] & ~ser2;
            if (ser2[UPMUX_PIN_TX]) begin
                c2_out_q[UPMUX_PIN_TX] <= chan2_tx_serial;
                c2_oe_q[UPMUX_PIN_TX] <= 1'b1;
                c2_out_q[UPMUX_PIN_RTS] <= chan2_rx_ready;
                c2_oe_q[UPMUX_PIN_RTS] <= 1'b1;
            end
            if (uart2) begin
                c2_out_q[UPMUX_PIN_DTR] <= chan2_link_ready;
                c2_oe_q[UPMUX_PIN_DTR] <= 1'b1;
            end
        end
    end
    assign pins.chan2_dev_out = c2_out_q;
    assign pins.chan2_dev_oe = c2_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Inputs to the cores; idle values when the pin is not serial
    always_ff @(posedge clock) begin
        if (reset) begin
            chan1_rx_serial <= 1'b1;
            chan1_clear_to_send <= 1'b0;
            chan1_carrier_detect <= 1'b0;
            chan1_set_ready <= 1'b0;
            clocked_serial_in <= 1'b0;
        end else begin
            // Idle line is high so a GP pin never fakes a start bit
            chan1_rx_serial <= ser1[UPMUX_PIN_RX] ? p1[UPMUX_PIN_RX] : 1'b1;
            chan1_clear_to_send <= ser1[UPMUX_PIN_CTS] & p1[UPMUX_PIN_CTS];
            chan1_carrier_detect <= uart1 & p1[UPMUX_PIN_DCD];
            chan1_set_ready <= uart1 & p1[UPMUX_PIN_DSR];
            clocked_serial_in <= csi1 & p1[UPMUX_PIN_DCD];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            chan2_rx_serial <= 1'b1;
            chan2_clear_to_send <= 1'b0;
            chan2_carrier_detect <= 1'b0;
            chan2_set_ready <= 1'b0;
        end else begin
            chan2_rx_serial <= ser2[UPMUX_PIN_RX] ? p2[UPMUX_PIN_RX] : 1'b1;
            chan2_clear_to_send <= ser2[UPMUX_PIN_CTS] & p2[UPMUX_PIN_CTS];
            chan2_carrier_detect <= uart2 & p2[UPMUX_PIN_DCD];
            chan2_set_ready <= uart2 & p2[UPMUX_PIN_DSR];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared clock and port readback
    always_ff @(posedge clock) begin
        if (reset) begin
            shared_serial_clock <= 1'b0;
            general_port_bits <= 14'h0000;
        end else begin
            // One input feeds both channels; sampled, so it must run well below clock
            shared_serial_clock <= sync2_q[14];
            general_port_bits <= {p2 & ~ser2, p1 & ~ser1};
        end
    end
endmodule // upmux_device
`default_nettype wire

// >>> rtl/upmux_partner.sv
`timescale 1ns/1ps
`default_nettype none
module upmux_partner
    import upmux_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    upmux_if.partner pins,
    input wire logic [1:0] chan1_pin_select,
    input wire logic [1:0] chan2_pin_select,
    input wire logic [1:0] tx_serial,
    input wire logic [1:0] rx_ready,
    input wire logic [1:0] link_ready,
    input wire logic [1:0] receiving,
    input wire logic clocked_serial_in,
    input wire logic clock_enable,
    output logic [1:0] rx_serial,
    output logic [1:0] peer_rx_ready,
    output logic [1:0] peer_link_ready,
    output logic clocked_serial_out,
    output logic clocked_serial_clock
);
    ////////////////////////////////////////////////////////////////////////
    // Which pins the partner may drive in the current modes
    function automatic logic [6:0] drive_mask(input logic [1:0] sel, input logic two);
        logic [1:0] m;
        m = (two && sel == UPMUX_MODE_CSI_UART) ? UPMUX_MODE_UART : sel;
        unique case (m)
            UPMUX_MODE_UART: drive_mask = 7'h69; // RX, CTS, DCD, DSR
            UPMUX_MODE_CSI_UART: drive_mask = 7'h29; // DCD carries clocked data in
            UPMUX_MODE_GP_UART: drive_mask = 7'h09;
            UPMUX_MODE_GP: drive_mask = UPMUX_ZERO7;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Partner pin drivers
    logic [6:0] o1_q;
    logic [6:0] o2_q;
    logic [6:0] e1_q;
    logic [6:0] e2_q;
    logic clk_q;
    always_ff @(posedge clock) begin
        if (reset) begin
            o1_q <= UPMUX_ZERO7;
            o2_q <= UPMUX_ZERO7;
            e1_q <= UPMUX_ZERO7;
            e2_q <= UPMUX_ZERO7;
        end else begin
            e1_q <= drive_mask(chan1_pin_select, 1'b0);
            e2_q <= drive_mask(chan2_pin_select, 1'b1);
            // Order dsr, dcd, dtr, cts, rts, tx, rx: readiness must land on the cts pin
            o1_q <= {link_ready[0], (chan1_pin_select == UPMUX_MODE_CSI_UART) ?
                     clocked_serial_in : receiving[0], 1'b0, rx_ready[0], 2'h0,
                     tx_serial[0]};
            o2_q <= {link_ready[1], receiving[1], 1'b0, rx_ready[1], 2'h0, tx_serial[1]};
        end
    end

    // Divided serial clock for the shared input
    always_ff @(posedge clock) begin
        if (reset) begin
            clk_q <= 1'b0;
        end else if (clock_enable) begin
            clk_q <= ~clk_q;
        end
    end
    assign pins.chan1_ext_out = o1_q;
    assign pins.chan1_ext_oe = e1_q;
    assign pins.chan2_ext_out = o2_q;
    assign pins.chan2_ext_oe = e2_q;
    assign pins.shared_serial_clock_in = clk_q;

    ////////////////////////////////////////////////////////////////////////
    // Sampled device-driven pins
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_serial <= 2'h3;
            peer_rx_ready <= 2'h0;
            peer_link_ready <= 2'h0;
            clocked_serial_out <= 1'b0;
            clocked_serial_clock <= 1'b0;
        end else begin
            rx_serial <= {pins.chan2_pin[UPMUX_PIN_TX], pins.chan1_pin[UPMUX_PIN_TX]};
            peer_rx_ready <= {pins.chan2_pin[UPMUX_PIN_RTS], pins.chan1_pin[UPMUX_PIN_RTS]};
            peer_link_ready <= {pins.chan2_pin[UPMUX_PIN_DTR], pins.chan1_pin[UPMUX_PIN_DTR]};
            clocked_serial_out <= pins.chan1_pin[UPMUX_PIN_DTR];
            clocked_serial_clock <= pins.chan1_pin[UPMUX_PIN_DSR];
        end
    end
endmodule // upmux_partner
`default_nettype wire

// >>> tb/upmux_props.sv
`timescale 1ns/1ps
`default_nettype none
module upmux_props
    import upmux_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [1:0] chan1_pin_select,
    input wire logic [1:0] chan2_pin_select,
    input wire logic [13:0] gp_oe,
    input wire logic [6:0] chan1_dev_oe,
    input wire logic [6:0] chan2_dev_oe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive is registered, so only judge it once the selector held for an edge
    logic run_q;
    logic [1:0] sel1_q;
    logic [1:0] sel2_q;
    logic ok1;
    logic ok2;
    always_ff @(posedge clock) begin
        run_q <= !reset;
        sel1_q <= chan1_pin_select;
        sel2_q <= chan2_pin_select;
    end
    assign ok1 = run_q && chan1_pin_select == sel1_q;
    assign ok2 = run_q && chan2_pin_select == sel2_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Output enables per mode: rx and cts in, tx and rts out unless GP, where port enables follow gp_oe
    a_ser_dir_ch1: assert property (
        ok1 && chan1_pin_select != UPMUX_MODE_GP |-> chan1_dev_oe[3:0] == 4'h6)
        else $error("channel one serial pin directions wrong");
    a_csi_pin_dirs: assert property (
        ok1 && chan1_pin_select == UPMUX_MODE_CSI_UART |-> chan1_dev_oe[6:4] == 3'h5)
        else $error("clocked serial pin directions wrong");
    a_uart_modem_ch1: assert property (
        ok1 && chan1_pin_select == UPMUX_MODE_UART |-> chan1_dev_oe[6:4] == 3'h1)
        else $error("channel one modem pin directions wrong");
    a_ser_dir_ch2: assert property (
        ok2 && chan2_pin_select != UPMUX_MODE_GP |-> chan2_dev_oe[3:0] == 4'h6)
        else $error("channel two serial pin directions wrong");
    a_modem_ch2_dirs: assert property (
        ok2 && chan2_pin_select inside {UPMUX_MODE_UART, UPMUX_MODE_CSI_UART}
        |-> chan2_dev_oe[6:4] == 3'h1)
        else $error("channel two modem pin directions wrong");
    a_gp_follow_ch1: assert property (
        ok1 && chan1_pin_select == UPMUX_MODE_GP |-> chan1_dev_oe == $past(gp_oe[6:0]))
        else $error("channel one port enables do not follow");
    a_gp_modem_ch1: assert property (
        ok1 && chan1_pin_select == UPMUX_MODE_GP_UART
        |-> chan1_dev_oe[6:4] == $past(gp_oe[6:4]))
        else $error("channel one modem port enables do not follow");
    a_gp_follow_ch2: assert property (
        ok2 && chan2_pin_select == UPMUX_MODE_GP |-> chan2_dev_oe == $past(gp_oe[13:7]))
        else $error("channel two port enables do not follow");
    c_csi_mode: cover property (ok1 && chan1_pin_select == UPMUX_MODE_CSI_UART);
    c_gp_uart_two: cover property (ok2 && chan2_pin_select == UPMUX_MODE_GP_UART);
    c_both_uart: cover property (ok1 && ok2 && chan1_pin_select == UPMUX_MODE_UART
        && chan2_pin_select == UPMUX_MODE_UART);
endmodule // upmux_props
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import upmux_pkg::*;;
    typedef struct packed {
        logic [8:0] de;
        logic [8:0] dm;
        logic [7:0] pe;
        logic [7:0] pm;
        logic [13:0] ge;
    } upmux_note_t;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [1:0] chan1_pin_select = 2'h3;
    logic [1:0] chan2_pin_select = 2'h3;
    logic [1:0] dev_tx = 2'h3, dev_rdy = 2'h0, dev_link = 2'h0;
    logic cs_out = 1'b0, cs_clk = 1'b0, p_csin = 1'b0, clk_en = 1'b0, check_req = 1'b0;
    logic [13:0] gp_out = 14'h0000, gp_oe = 14'h0000;
    logic [1:0] p_tx = 2'h3, p_rdy = 2'h0, p_link = 2'h0, p_recv = 2'h0;
    logic [1:0] p_rxs, p_prr, p_plr;
    logic c1rx, c1cts, c1dcd, c1dsr, c2rx, c2cts, c2dcd, c2dsr, csi_in, sclk, p_cso, p_csc;
    logic [13:0] gp_bits;
    // Core-side and partner-side results gathered in the order of the notes
    logic [8:0] dev_seen;
    logic [7:0] prt_seen;
    assign dev_seen = {c1rx, c1cts, c1dcd, c1dsr, c2rx, c2cts, c2dcd, c2dsr, csi_in};
    assign prt_seen = {p_rxs[0], p_prr[0], p_plr[0], p_rxs[1], p_prr[1], p_plr[1], p_cso, p_csc};
    int n_mismatch = 0;
    int checks = 0;
    upmux_note_t notes[$];
    upmux_note_t cur;
    ////////////////////////////////////////////////////////////////////////////////
    // Both ends joined through the pin interface
    upmux_if upmux_if_inst();
    upmux_device upmux_device_inst(.clock(clock), .reset(reset), .pins(upmux_if_inst.device),
        .chan1_pin_select(chan1_pin_select), .chan2_pin_select(chan2_pin_select),
        .chan1_tx_serial(dev_tx[0]), .chan1_rx_ready(dev_rdy[0]), .chan1_link_ready(dev_link[0]),
        .chan2_tx_serial(dev_tx[1]), .chan2_rx_ready(dev_rdy[1]), .chan2_link_ready(dev_link[1]),
        .clocked_serial_out(cs_out), .clocked_serial_clock(cs_clk), .gp_out(gp_out),
        .gp_oe(gp_oe), .chan1_rx_serial(c1rx), .chan1_clear_to_send(c1cts),
        .chan1_carrier_detect(c1dcd), .chan1_set_ready(c1dsr), .chan2_rx_serial(c2rx),
        .chan2_clear_to_send(c2cts), .chan2_carrier_detect(c2dcd), .chan2_set_ready(c2dsr),
        .clocked_serial_in(csi_in), .shared_serial_clock(sclk), .general_port_bits(gp_bits));
    upmux_partner upmux_partner_inst(.clock(clock), .reset(reset), .pins(upmux_if_inst.partner),
        .chan1_pin_select(chan1_pin_select), .chan2_pin_select(chan2_pin_select),
        .tx_serial(p_tx), .rx_ready(p_rdy), .link_ready(p_link), .receiving(p_recv),
        .clocked_serial_in(p_csin), .clock_enable(clk_en), .rx_serial(p_rxs),
        .peer_rx_ready(p_prr), .peer_link_ready(p_plr), .clocked_serial_out(p_cso),
        .clocked_serial_clock(p_csc));
    upmux_props upmux_props_inst(.clock(clock), .reset(reset), .gp_oe(gp_oe),
        .chan1_pin_select(chan1_pin_select), .chan2_pin_select(chan2_pin_select),
        .chan1_dev_oe(upmux_if_inst.chan1_dev_oe), .chan2_dev_oe(upmux_if_inst.chan2_dev_oe));
    // 100 MHz clock
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] m,
        input logic [15:0] g);
        checks++;
        if (((g ^ e) & m) !== 16'h0000) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h mask %h", what, e, g, m);
        end
    endtask
    // One task per kind of result, all judged through the masked compare above
    task automatic check_device(input upmux_note_t n);
        cmp("device", 16'(n.de), 16'(n.dm), 16'(dev_seen));
    endtask
    task automatic check_partner(input upmux_note_t n);
        cmp("partner", 16'(n.pe), 16'(n.pm), 16'(prt_seen));
    endtask
    task automatic check_ports(input upmux_note_t n);
        cmp("port bits", 16'(n.ge), 16'h3fff, 16'(gp_bits));
    endtask
    task automatic check_clock(input logic e, input logic g);
        cmp("shared clock moving", 16'(e), 16'h0001, 16'(g));
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Random levels on every core and pin input; expectation built from the mode
    task automatic apply(input logic [1:0] s1, input logic [1:0] s2);
        logic [31:0] r;
        logic [31:0] g;
        logic ser1, ser2, mdm1, mdm2, csi;
        logic [13:0] own;
        r = $urandom;
        g = $urandom;
        ser1 = s1 != UPMUX_MODE_GP;
        ser2 = s2 != UPMUX_MODE_GP;
        mdm1 = s1 == UPMUX_MODE_UART;
        mdm2 = s2 == UPMUX_MODE_UART || s2 == UPMUX_MODE_CSI_UART;
        csi = s1 == UPMUX_MODE_CSI_UART;
        own[6:0] = !ser1 ? 7'h7f : (s1 == UPMUX_MODE_GP_UART ? 7'h70 : 7'h00);
        own[13:7] = !ser2 ? 7'h7f : (s2 == UPMUX_MODE_GP_UART ? 7'h70 : 7'h00);
        @(posedge clock);
        chan1_pin_select <= s1;
        chan2_pin_select <= s2;
        // Even bit of each pair feeds channel one, odd bit channel two, matching the bit picks of the notes below
        {cs_clk, cs_out, dev_link, dev_rdy, dev_tx} <= r[7:0];
        {p_csin, p_recv, p_link, p_rdy, p_tx} <= r[16:8];
        {gp_out, gp_oe} <= g[27:0];
        cur.de = {ser1 ? r[8] : 1'b1, ser1 & r[10], mdm1 & r[14], mdm1 & r[12],
            ser2 ? r[9] : 1'b1, ser2 & r[11], mdm2 & r[15], mdm2 & r[13], r[16]};
        cur.dm = {8'hff, csi};
        cur.pe = {r[0], r[2], r[4], r[1], r[3], r[5], r[6], r[7]};
        cur.pm = {ser1, ser1, mdm1, ser2, ser2, mdm2, csi, csi};
        cur.ge = own & g[13:0] & g[27:14];
        // Pin register, two synchroniser stages and output flops on either end
        repeat (8) @(posedge clock);
        notes.push_back(cur);
        check_req <= 1'b1;
        @(posedge clock);
        check_req <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watcher takes the oldest note whenever a result is flagged
    always @(posedge clock) begin
        if (check_req && notes.size() == 0) begin
            n_mismatch++;
            $display("FAIL note queue expected entry seen empty");
        end else if (check_req) begin
            cur = notes.pop_front();
            check_device(cur);
            check_partner(cur);
            check_ports(cur);
        end
    end
    // Main sequence: every mode pair twice, then the shared clock
    initial begin
        int k;
        int toggles;
        logic last;
        void'($urandom(32'h9fb80134));
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        for (k = 0; k < 32; k++) apply(k[3:2], k[1:0]);
        for (k = 0; k < 2; k++) begin
            clk_en <= (k == 0);
            repeat (8) @(posedge clock);
            toggles = 0;
            last = sclk;
            repeat (40) begin
                @(posedge clock);
                if (sclk !== last) toggles++;
                last = sclk;
            end
            check_clock(k == 0, toggles != 0);
        end
        for (k = 0; k < 20 && notes.size() != 0; k++) @(posedge clock);
        if (notes.size() != 0) n_mismatch++;
        stop_test();
    end
endmodule // testbench
`default_nettype wire
